// ---- logic/acq_clk_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface acq_clk_if;
  logic [1:0]  mode;
  logic        mag;
  logic [31:0] period;
  logic        ext_level;
  logic        clk_out;
  modport gen (input mode, input mag, input period, input ext_level, output clk_out);
  modport ctl (output mode, output mag, output period, output ext_level, input clk_out);
endinterface : acq_clk_if
`default_nettype wire

// ---- logic/acq_clock_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module acq_clock_gen (
  input  wire logic aclk,    // System clock
  input  wire logic aresetn, // Sync reset, active low
  acq_clk_if.gen    cif      // Mode, rate and clock out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [9:0]  slow_cnt;
    logic        out;
  } gen_s;

  gen_s        q_r;
  gen_s        q_nxt;
  logic [31:0] half;
  logic [31:0] eff;

  always_comb begin
    q_nxt = q_r;
    eff   = cif.mag ? (cif.period / acq_pkg::MAG_FACTOR) : cif.period;
    half  = eff >> 1;
    if (half == 32'h0000_0000) begin
      half = 32'h0000_0001;
    end
    case (acq_pkg::clk_mode_e'(cif.mode))
      acq_pkg::CLK_INTERNAL: begin
        q_nxt.slow_cnt = 10'h000;
        if (q_r.cnt >= half - 32'h0000_0001) begin
          q_nxt.cnt = 32'h0000_0000;
          q_nxt.out = ~q_r.out;
        end else begin
          q_nxt.cnt = q_r.cnt + 32'h0000_0001;
        end
      end
      acq_pkg::CLK_SLOW: begin
        if (q_r.cnt >= half - 32'h0000_0001) begin
          q_nxt.cnt = 32'h0000_0000;
          // Toggle every 1000 half periods: same duty, rate over 1000
          if (q_r.slow_cnt == acq_pkg::SLOW_LAST) begin
            q_nxt.slow_cnt = 10'h000;
            q_nxt.out      = ~q_r.out;
          end else begin
            q_nxt.slow_cnt = q_r.slow_cnt + 10'h001;
          end
        end else begin
          q_nxt.cnt = q_r.cnt + 32'h0000_0001;
        end
      end
      acq_pkg::CLK_EXTERNAL: begin
        // Internal divider held idle; open input leaves output still
        q_nxt.cnt      = 32'h0000_0000;
        q_nxt.slow_cnt = 10'h000;
        q_nxt.out      = cif.ext_level;
      end
      default: begin
        q_nxt.cnt      = 32'h0000_0000;
        q_nxt.slow_cnt = 10'h000;
        q_nxt.out      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cif.clk_out = q_r.out;
endmodule : acq_clock_gen
`default_nettype wire

// ---- logic/acq_pkg.sv ----
`default_nettype none
package acq_pkg;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_PERIOD     = 8'h04;
  localparam logic [7:0]  OFF_STOP_DELAY = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h14;
  localparam logic [7:0]  OFF_POST_TIME  = 8'h18;

  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_MAG_BIT    = 2;
  localparam int unsigned CTRL_SINGLE_BIT = 3;
  localparam int unsigned CTRL_ARM_BIT    = 4;

  localparam int unsigned ST_ARMED_BIT = 0;
  localparam int unsigned ST_POST_BIT  = 1;
  localparam int unsigned ST_DONE_BIT  = 2;
  localparam int unsigned ST_BUSY_BIT  = 3;

  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_TRIG_BIT = 0;
  localparam int unsigned IRQ_STOP_BIT = 1;
  localparam int unsigned IRQ_BUSY_BIT = 2;

  typedef enum logic [1:0] {CLK_INTERNAL, CLK_SLOW, CLK_EXTERNAL} clk_mode_e;

  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam logic [31:0] PERIOD_RST     = 32'h0000_0400;
  localparam logic [31:0] STOP_DELAY_RST = 32'h0000_0064;
  localparam logic [31:0] MAG_FACTOR     = 32'h0000_000A;
  localparam logic [9:0]  SLOW_LAST      = 10'h3E7;
  localparam int unsigned CLK_PERIOD_NS  = 10;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : acq_pkg
`default_nettype wire

// ---- logic/acquire_clock_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module acquire_clock_top (
  input  wire logic        aclk,              // System clock, 100 MHz
  input  wire logic        aresetn,           // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  input  wire logic        ext_clk_in,        // External TTL clock pin
  input  wire logic        sweep_trig_in,     // Sweep trigger pin
  input  wire logic        digitizer_busy_in, // Digitizer busy pin
  output logic             acquire_clk,       // Acquire clock to digitizer
  output logic             acquire_stop,      // Acquire-stop pulse
  output logic             intensify,         // Post-trigger intensify
  output logic             ready_lamp,        // Single sweep armed
  output logic             irq                // Interrupt, active high
);
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_POST, S_DONE} sweep_e;

  typedef struct packed {
    // Software-visible settings
    logic [1:0]             mode;
    logic                   mag;
    logic                   single;
    logic [31:0]            period;
    logic [31:0]            stop_delay;
    logic [acq_pkg::IRQ_W-1:0] irq_stat;
    logic [acq_pkg::IRQ_W-1:0] irq_mask;

    // Two-flop pin synchronisers, one extra flop for edges
    logic                   ext_s1;
    logic                   ext_s2;
    logic                   trig_s1;
    logic                   trig_s2;
    logic                   trig_d;
    logic                   busy_s1;
    logic                   busy_s2;
    logic                   busy_d;

    // Sweep sequencer
    sweep_e                 state;
    logic [31:0]            dly_cnt;
    logic                   stop;
    logic                   intens;
    logic                   ready;
    logic                   irq;

    // Bus channel holding state
    logic                   aw_got;
    logic [7:0]             aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   awready;
    logic                   wready;
    logic                   arready;
  } top_s;

  top_s                      q_r;
  top_s                      q_nxt;
  logic                      trig_edge;
  logic                      busy_rise;
  logic                      arm;
  logic                      do_write;
  logic [31:0]               ctrl_word;
  logic [31:0]               ctrl_new;
  logic [acq_pkg::IRQ_W-1:0] irq_set;
  logic [acq_pkg::IRQ_W-1:0] irq_clr;

  acq_clk_if cif ();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == acq_pkg::OFF_CTRL) || (a == acq_pkg::OFF_PERIOD) ||
           (a == acq_pkg::OFF_STOP_DELAY) || (a == acq_pkg::OFF_STATUS) ||
           (a == acq_pkg::OFF_IRQ_STAT) || (a == acq_pkg::OFF_IRQ_MASK) ||
           (a == acq_pkg::OFF_POST_TIME);
  endfunction : mapped

  always_comb begin
    q_nxt     = q_r;
    ctrl_word = 32'h0000_0000;
    ctrl_word[acq_pkg::CTRL_MODE_LSB +: 2] = q_r.mode;
    ctrl_word[acq_pkg::CTRL_MAG_BIT]       = q_r.mag;
    ctrl_word[acq_pkg::CTRL_SINGLE_BIT]    = q_r.single;
    ctrl_new  = merge(ctrl_word, q_r.w_data, q_r.w_strb);
    irq_set   = '0;
    irq_clr   = '0;
    arm       = 1'b0;

    // Pin synchronisers
    q_nxt.ext_s1  = ext_clk_in;
    q_nxt.ext_s2  = q_r.ext_s1;
    q_nxt.trig_s1 = sweep_trig_in;
    q_nxt.trig_s2 = q_r.trig_s1;
    q_nxt.trig_d  = q_r.trig_s2;
    q_nxt.busy_s1 = digitizer_busy_in;
    q_nxt.busy_s2 = q_r.busy_s1;
    q_nxt.busy_d  = q_r.busy_s2;
    trig_edge     = q_r.trig_s2 & ~q_r.trig_d;
    busy_rise     = q_r.busy_s2 & ~q_r.busy_d;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !q_r.aw_got && !q_r.bvalid) begin
      q_nxt.aw_got  = 1'b1;
      q_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_r.w_got && !q_r.bvalid) begin
      q_nxt.w_got  = 1'b1;
      q_nxt.w_data = s_axi_wdata;
      q_nxt.w_strb = s_axi_wstrb;
    end
    // Response only once both halves are held
    do_write = q_r.aw_got && q_r.w_got && !q_r.bvalid;
    if (do_write) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = mapped(q_r.aw_addr) ? acq_pkg::RESP_OKAY : acq_pkg::RESP_SLVERR;
      case (q_r.aw_addr)
        acq_pkg::OFF_CTRL: begin
          q_nxt.mode   = ctrl_new[acq_pkg::CTRL_MODE_LSB +: 2];
          q_nxt.mag    = ctrl_new[acq_pkg::CTRL_MAG_BIT];
          q_nxt.single = ctrl_new[acq_pkg::CTRL_SINGLE_BIT];
          // Arm is a write-one strobe, never stored, reads back zero
          arm          = q_r.w_strb[0] & q_r.w_data[acq_pkg::CTRL_ARM_BIT];
        end
        acq_pkg::OFF_PERIOD: begin
          q_nxt.period = merge(q_r.period, q_r.w_data, q_r.w_strb);
        end
        acq_pkg::OFF_STOP_DELAY: begin
          q_nxt.stop_delay = merge(q_r.stop_delay, q_r.w_data, q_r.w_strb);
        end
        acq_pkg::OFF_IRQ_STAT: begin
          irq_clr = q_r.w_strb[0] ? q_r.w_data[acq_pkg::IRQ_W-1:0] : '0;
        end
        acq_pkg::OFF_IRQ_MASK: begin
          if (q_r.w_strb[0]) begin
            q_nxt.irq_mask = q_r.w_data[acq_pkg::IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && !q_r.rvalid) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = mapped(s_axi_araddr) ? acq_pkg::RESP_OKAY : acq_pkg::RESP_SLVERR;
      q_nxt.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        acq_pkg::OFF_CTRL: begin
          q_nxt.rdata = ctrl_word;
        end
        acq_pkg::OFF_PERIOD: begin
          q_nxt.rdata = q_r.period;
        end
        acq_pkg::OFF_STOP_DELAY: begin
          q_nxt.rdata = q_r.stop_delay;
        end
        acq_pkg::OFF_STATUS: begin
          q_nxt.rdata[acq_pkg::ST_ARMED_BIT] = (q_r.state == S_ARMED);
          q_nxt.rdata[acq_pkg::ST_POST_BIT]  = (q_r.state == S_POST);
          q_nxt.rdata[acq_pkg::ST_DONE_BIT]  = (q_r.state == S_DONE);
          q_nxt.rdata[acq_pkg::ST_BUSY_BIT]  = q_r.busy_s2;
        end
        acq_pkg::OFF_IRQ_STAT: begin
          q_nxt.rdata[acq_pkg::IRQ_W-1:0] = q_r.irq_stat;
        end
        acq_pkg::OFF_IRQ_MASK: begin
          q_nxt.rdata[acq_pkg::IRQ_W-1:0] = q_r.irq_mask;
        end
        // Post-trigger time shown is the stop delay in every clock mode
        acq_pkg::OFF_POST_TIME: begin
          q_nxt.rdata = q_r.stop_delay;
        end
        default: begin
          q_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end else if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end

    // Sweep sequencer
    q_nxt.stop = 1'b0;
    case (q_r.state)
      S_IDLE, S_DONE: begin
        if (q_r.single) begin
          if (arm) begin
            q_nxt.state = S_ARMED;
          end
        end else if (trig_edge) begin
          q_nxt.state   = S_POST;
          q_nxt.dly_cnt = 32'h0000_0000;
          irq_set[acq_pkg::IRQ_TRIG_BIT] = 1'b1;
        end
      end
      S_ARMED: begin
        // Dropping single while armed disarms without a sweep
        if (!q_r.single) begin
          q_nxt.state = S_IDLE;
        end else if (trig_edge) begin
          q_nxt.state   = S_POST;
          q_nxt.dly_cnt = 32'h0000_0000;
          irq_set[acq_pkg::IRQ_TRIG_BIT] = 1'b1;
        end
      end
      S_POST: begin
        // Delay counted in aclk cycles, independent of clock mode
        if (q_r.dly_cnt >= q_r.stop_delay) begin
          q_nxt.stop  = 1'b1;
          q_nxt.state = q_r.single ? S_DONE : S_IDLE;
          irq_set[acq_pkg::IRQ_STOP_BIT] = 1'b1;
        end else begin
          q_nxt.dly_cnt = q_r.dly_cnt + 32'h0000_0001;
        end
      end
      default: begin
        q_nxt.state = S_IDLE;
      end
    endcase
    q_nxt.intens = (q_nxt.state == S_POST);
    q_nxt.ready  = (q_nxt.state == S_ARMED);
    irq_set[acq_pkg::IRQ_BUSY_BIT] = busy_rise;

    // New event beats a simultaneous clear
    q_nxt.irq_stat = (q_r.irq_stat & ~irq_clr) | irq_set;
    q_nxt.irq      = |(q_nxt.irq_stat & q_nxt.irq_mask);

    // Readies registered so every bus output leaves a flop
    q_nxt.awready  = ~q_nxt.aw_got & ~q_nxt.bvalid;
    q_nxt.wready   = ~q_nxt.w_got & ~q_nxt.bvalid;
    q_nxt.arready  = ~q_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r            <= '0;
      q_r.mode       <= acq_pkg::MODE_RST;
      q_r.period     <= acq_pkg::PERIOD_RST;
      q_r.stop_delay <= acq_pkg::STOP_DELAY_RST;
      q_r.state      <= S_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cif.mode      = q_r.mode;
  assign cif.mag       = q_r.mag;
  assign cif.period    = q_r.period;
  assign cif.ext_level = q_r.ext_s2;

  acq_clock_gen u_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif.gen)
  );

  assign s_axi_awready = q_r.awready;
  assign s_axi_wready  = q_r.wready;
  assign s_axi_bvalid  = q_r.bvalid;
  assign s_axi_bresp   = q_r.bresp;
  assign s_axi_arready = q_r.arready;
  assign s_axi_rvalid  = q_r.rvalid;
  assign s_axi_rdata   = q_r.rdata;
  assign s_axi_rresp   = q_r.rresp;
  assign acquire_clk   = cif.clk_out;
  assign acquire_stop  = q_r.stop;
  assign intensify     = q_r.intens;
  assign ready_lamp    = q_r.ready;
  assign irq           = q_r.irq;
endmodule : acquire_clock_top
`default_nettype wire

// ---- sim/acq_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module acq_sva (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, low
  input wire logic        s_axi_awready, // AW ready
  input wire logic        s_axi_wready,  // W ready
  input wire logic [1:0]  s_axi_bresp,   // B resp
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic        s_axi_arready, // AR ready
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready,  // R ready
  input wire logic        sweep_trig_in, // Trigger pin
  input wire logic        acquire_stop,  // Stop pulse
  input wire logic        intensify,     // Post zone
  input wire logic        ready_lamp     // Armed lamp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_STOP_PULSE: assert property (acquire_stop |=> !acquire_stop)
    else $error("stop pulse too long");
  AST_STOP_POST: assert property (acquire_stop |-> $past(intensify))
    else $error("stop outside post zone");
  AST_TRIG_POST: assert property ($rose(intensify) |-> $past(sweep_trig_in, 2))
    else $error("post zone without trigger");
  AST_LAMP_POST: assert property (intensify |-> !ready_lamp)
    else $error("lamp lit during sweep");
  AST_STOP_END: assert property (acquire_stop |=> !intensify [*2])
    else $error("sweep goes on after stop");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  COV_STOP: cover property (acquire_stop);
  COV_ARM: cover property ($rose(ready_lamp));
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : acq_sva
bind acquire_clock_top acq_sva u_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .sweep_trig_in, .acquire_stop, .intensify, .ready_lamp);
`default_nettype wire

// ---- sim/digitizer_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module digitizer_model #(
  parameter int DEPTH   = 8, // Record points
  parameter int PULSES  = 1, // Clock pulses per point
  parameter int MIN_GAP = 2  // Fastest clock, cycles
) (
  input  wire logic aclk,         // Clock
  input  wire logic aresetn,      // Reset, low
  input  wire logic acquire_clk,  // Sample clock
  input  wire logic acquire_stop, // Stop pulse
  input  wire logic start,        // Single shot request
  input  wire logic abort,        // Rear stop button
  output logic      busy,         // Busy lamp
  output logic      err,          // Clock too fast
  output int        records       // Records stored
);
  logic clk_d;
  int   pulses;
  int   points;
  int   gap;
  always @(posedge aclk) begin
    clk_d <= acquire_clk;
    gap <= gap + 1;
    if (!aresetn) begin
      records <= 0;
      err <= 1'b0;
    end
    if (!aresetn || abort) begin
      busy <= 1'b0;
      pulses <= 0;
      points <= 0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      err <= 1'b0;
      pulses <= 0;
      points <= 0;
    end else if (busy) begin
      if (acquire_clk && !clk_d) begin
        gap <= 0;
        if (gap < MIN_GAP) err <= 1'b1;
        pulses <= (pulses == PULSES - 1) ? 0 : pulses + 1;
        if (pulses == PULSES - 1 && points < DEPTH) points <= points + 1;
      end
      // Early stop is dropped, acquisition keeps running
      if (acquire_stop && points == DEPTH) begin
        busy <= 1'b0;
        if (!err) records <= records + 1;
      end
    end
  end
endmodule : digitizer_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] rx;} row_s;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, ext_clk, ext_run, trig;
  logic        awready, wready, bvalid, arready, rvalid, acq_clk, acq_stop;
  logic        intens, lamp, irq, busy, d_start, d_abort, derr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          n_errors, checks_done, n, d1, recs, ecnt, tcnt;
  row_s        rows [4];
  acquire_clock_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ext_clk_in(ext_clk),
    .sweep_trig_in(trig), .digitizer_busy_in(busy), .acquire_clk(acq_clk),
    .acquire_stop(acq_stop), .intensify(intens), .ready_lamp(lamp), .irq(irq));
  digitizer_model u_dig (.aclk(aclk), .aresetn(aresetn), .acquire_clk(acq_clk),
    .acquire_stop(acq_stop), .start(d_start), .abort(d_abort), .busy(busy), .err(derr),
    .records(recs));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // External TTL source, period 14 cycles, still when off
  always @(posedge aclk) begin
    ecnt <= (ecnt == 6) ? 0 : ecnt + 1;
    if (ext_run && ecnt == 6) ext_clk <= !ext_clk;
    tcnt <= trig ? tcnt + 1 : 0;
    if (tcnt == 9) trig <= 1'b0;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Ready sampled at negedge: flops are settled there, no race with the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tf;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tf = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tf) break;
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ta, tv;
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tv = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tv) break;
    end
  endtask : rdr
  task automatic meas(output int p);
    logic pv;
    int e;
    e = 0;
    p = 0;
    pv = acq_clk;
    for (int i = 0; i < 9000 && e < 2; i++) begin
      @(negedge aclk);
      if (e == 1) p++;
      if (acq_clk && !pv) e++;
      pv = acq_clk;
    end
    if (e < 2) p = -1;
    @(posedge aclk);
  endtask : meas
  task automatic sweep(output int s);
    logic on;
    on = 1'b0;
    s = -1;
    trig <= 1'b1;
    for (int i = 0; i < 600 && !acq_stop; i++) begin
      @(negedge aclk);
      on = on | intens;
      if (on) s++;
    end
    if (!acq_stop) s = -1;
    @(posedge aclk);
  endtask : sweep
  task automatic shot(input logic [31:0] ctrl);
    // Clock mode first, so the record can fill before arming
    wr(acq_pkg::OFF_CTRL, ctrl & 32'hFFFF_FFEF);
    d_start <= 1'b1;
    @(posedge aclk);
    d_start <= 1'b0;
    repeat (200) @(posedge aclk);
    wr(acq_pkg::OFF_CTRL, ctrl);
    repeat (2) @(posedge aclk);
    chk(lamp, 1'b1);
    rdr(acq_pkg::OFF_STATUS);
    chk(rd, 32'h9);
  endtask : shot
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, ext_clk, ext_run, trig, d_start, d_abort} = '0;
    {awaddr, araddr, wdata, ecnt, tcnt} = '0;
    rows[0] = '{acq_pkg::OFF_PERIOD, 32'h14, acq_pkg::OFF_PERIOD, 32'h14};
    rows[1] = '{acq_pkg::OFF_STOP_DELAY, 32'h20, acq_pkg::OFF_POST_TIME, 32'h20};
    rows[2] = '{acq_pkg::OFF_IRQ_MASK, 32'h7, acq_pkg::OFF_IRQ_MASK, 32'h7};
    rows[3] = '{8'h40, 32'h5, 8'h40, 32'h0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(acq_pkg::OFF_PERIOD);
    chk(rd, acq_pkg::PERIOD_RST);
    rdr(acq_pkg::OFF_STOP_DELAY);
    chk(rd, acq_pkg::STOP_DELAY_RST);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      chk(rs, (i == 3) ? acq_pkg::RESP_SLVERR : acq_pkg::RESP_OKAY);
      rdr(rows[i].ra);
      chk(rs, (i == 3) ? acq_pkg::RESP_SLVERR : acq_pkg::RESP_OKAY);
      chk(rd, rows[i].rx);
    end
    wr(acq_pkg::OFF_CTRL, 32'h0);
    meas(n);
    chk(n, 20);
    wr(acq_pkg::OFF_CTRL, 32'h4);
    meas(n);
    chk(n, 2);
    wr(acq_pkg::OFF_CTRL, 32'h5);
    meas(n);
    chk(n, 2000);
    ext_run <= 1'b1;
    wr(acq_pkg::OFF_CTRL, 32'h6);
    meas(n);
    chk(n, 14);
    ext_run <= 1'b0;
    meas(n);
    chk(n, -1);
    wr(acq_pkg::OFF_CTRL, 32'h3);
    repeat (2) @(posedge aclk);
    chk(acq_clk, 1'b0);
    shot(32'h18);
    sweep(d1);
    chk(d1 >= 32 && d1 <= 36, 1'b1);
    @(posedge aclk);
    chk(recs, 1);
    chk(derr, 1'b0);
    sweep(n);
    chk(n, -1);
    rdr(acq_pkg::OFF_IRQ_STAT);
    chk(rd, 32'h7);
    chk(irq, 1'b1);
    wr(acq_pkg::OFF_IRQ_STAT, 32'h7);
    wr(acq_pkg::OFF_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(acq_pkg::OFF_STOP_DELAY, 32'h40);
    // Slow clock never fills the record, so this stop must be ignored
    shot(32'h19);
    sweep(n);
    chk(n - d1, 32);
    chk(busy, 1'b1);
    rdr(acq_pkg::OFF_IRQ_STAT);
    chk(rd, 32'h7);
    chk(irq, 1'b0);
    d_abort <= 1'b1;
    @(posedge aclk);
    d_abort <= 1'b0;
    @(posedge aclk);
    chk(busy, 1'b0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
